// ### pkg/module_info_pkg.sv
// constants and enumerations for the module information store slave
// assumes one 100 MHz system clock and a free running link sampling clock
package module_info_pkg;

    localparam int          DATA_W       = 8;
    localparam int          ADDR_W       = 8;
    localparam int          MEM_BYTES    = 256;
    localparam logic [3:0]  TYPE_MEMORY  = 4'ha;
    localparam logic [3:0]  TYPE_PROTECT = 4'h6;
    localparam logic [4:0]  PAGE_BYTES   = 5'h10;
    localparam int          FIFO_DEPTH   = 16;
    localparam int          FIFO_W       = 1 + ADDR_W + DATA_W;
    localparam logic [7:0]  PROT_RESET   = 8'h00;
    localparam logic [7:0]  RD_RESET     = 8'hff;
    localparam int          MCLK_MHZ     = 100;
    localparam int          INTERNAL_PROGRAM_TIME_MS = 10;
    localparam int          PROG_CYCLES  = INTERNAL_PROGRAM_TIME_MS * 1000 * MCLK_MHZ;
    localparam int          PROG_CNT_W   = 20;

    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_COMMIT
    } req_op_t;

endpackage

// ### hw/stream_fifo.sv
// single clock first-in first-out buffer with valid/ready on both sides
// assumes both sides run on the same clock and reset
`timescale 1ns/100ps
`default_nettype none

module stream_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   fill;
    logic             push;
    logic             pop;

    assign in_ready  = (fill != (PTR_W+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = store[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                fill <= fill + 1'b1;
            end else if (pop && !push) begin
                fill <= fill - 1'b1;
            end
        end
    end

endmodule // stream_fifo

`default_nettype wire

// ### hw/module_info_store.sv
// two-wire serial slave of the module information store with its byte array
// assumes link_clk runs free and much faster than the serial clock; sda is open drain
`timescale 1ns/100ps
`default_nettype none

module module_info_store #(
    parameter int PROG_CYCLES_P = module_info_pkg::PROG_CYCLES
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic link_clk,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_n,
    input  wire logic select_strap_bit2,
    input  wire logic select_strap_bit1,
    input  wire logic select_strap_bit0,
    input  wire logic write_control_input,
    output logic      prog_busy
);

    import module_info_pkg::*;

    localparam logic [PROG_CNT_W-1:0] PROG_LAST = PROG_CNT_W'(PROG_CYCLES_P - 1);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TXWAIT,
        ST_TX,
        ST_TACK,
        ST_WAITSTOP
    } link_state_t;

    typedef enum logic [1:0] {
        M_IDLE,
        M_DRAIN,
        M_PROG
    } prog_state_t;

    // link domain
    logic        lrst_m;
    logic        link_rst;
    logic        scl_m, scl_s, scl_d;
    logic        sda_m, sda_s, sda_d;
    logic [2:0]  strap_m, strap_s;
    logic        wrctl_m, wrctl_s;
    logic        busy_m, busy_s;
    logic        ack_m, ack_s;
    logic        scl_rise, scl_fall, start_det, stop_det;
    logic        hs_pending;
    link_state_t state;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  txsh;
    logic [1:0]  phase;
    logic        rd_mode;
    logic        prot_sel;
    logic [7:0]  addr;
    logic [4:0]  page_cnt;
    logic        wrote_any;
    logic        req_tgl;
    req_op_t     req_op;
    logic        req_prot;
    logic [7:0]  req_addr;
    logic [7:0]  req_data;
    logic        sel_match;

    // system domain
    logic              req_s1, req_s2, req_s3;
    logic              mpend;
    logic              ack_tgl;
    logic [7:0]        rd_data;
    prog_state_t       m_state;
    logic [PROG_CNT_W-1:0] prog_cnt;
    logic [7:0]        prot_reg;
    logic [7:0]        mem [0:MEM_BYTES-1];
    logic              fifo_in_valid, fifo_in_ready;
    logic              fifo_out_valid, fifo_out_ready;
    logic [FIFO_W-1:0] fifo_out_data;
    logic              service;

    ////////////////////////////////////////////////////////////////////////////////
    // link side synchronisers

    always_ff @(posedge link_clk) begin
        lrst_m   <= rst;
        link_rst <= lrst_m;
        scl_m    <= scl_in;
        scl_s    <= scl_m;
        scl_d    <= scl_s;
        sda_m    <= sda_in;
        sda_s    <= sda_m;
        sda_d    <= sda_s;
        strap_m  <= {select_strap_bit2, select_strap_bit1, select_strap_bit0};
        strap_s  <= strap_m;
        wrctl_m  <= write_control_input;
        wrctl_s  <= wrctl_m;
        busy_m   <= prog_busy;
        busy_s   <= busy_m;
        ack_m    <= ack_tgl;
        ack_s    <= ack_m;
    end

    assign scl_rise   = scl_s && !scl_d;
    assign scl_fall   = !scl_s && scl_d;
    assign start_det  = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det   = scl_s && scl_d && !sda_d && sda_s;
    assign hs_pending = req_tgl ^ ack_s;

    assign sel_match = !busy_s && !hs_pending && (shreg[3:1] == strap_s)
                       && (shreg[7:4] == TYPE_MEMORY || shreg[7:4] == TYPE_PROTECT);

    // open drain: only ever pull low
    assign sda_out  = 1'b0;
    assign sda_oe_n = !((state == ST_ACK) || (state == ST_TX && !txsh[7]));

    ////////////////////////////////////////////////////////////////////////////////
    // link state machine

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            state     <= ST_IDLE;
            bitcnt    <= 4'h0;
            shreg     <= 8'h00;
            txsh      <= 8'hff;
            phase     <= 2'h0;
            rd_mode   <= 1'b0;
            prot_sel  <= 1'b0;
            addr      <= 8'h00;
            page_cnt  <= 5'h00;
            wrote_any <= 1'b0;
            req_tgl   <= 1'b0;
            req_op    <= OP_READ;
            req_prot  <= 1'b0;
            req_addr  <= 8'h00;
            req_data  <= 8'h00;
        end else if (start_det) begin
            state  <= ST_RX;
            bitcnt <= 4'h0;
            phase  <= 2'h0;
        end else if (stop_det) begin
            state <= ST_IDLE;
            if (wrote_any) begin
                wrote_any <= 1'b0;
                req_op    <= OP_COMMIT;
                req_tgl   <= ~req_tgl;
            end
        end else begin
            case (state)
                ST_RX: begin
                    if (scl_rise && bitcnt != 4'h8) begin
                        shreg  <= {shreg[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'h8) begin
                        if (phase == 2'h0) begin
                            if (sel_match) begin
                                state    <= ST_ACK;
                                phase    <= 2'h1;
                                rd_mode  <= shreg[0];
                                prot_sel <= (shreg[7:4] == TYPE_PROTECT);
                                if (shreg[0]) begin
                                    req_op   <= OP_READ;
                                    req_prot <= (shreg[7:4] == TYPE_PROTECT);
                                    req_addr <= addr;
                                    req_tgl  <= ~req_tgl;
                                    addr     <= addr + 8'h01;
                                end
                            end else begin
                                state <= ST_IDLE;
                            end
                        end else if (phase == 2'h1) begin
                            state    <= ST_ACK;
                            phase    <= 2'h2;
                            addr     <= shreg;
                            page_cnt <= 5'h00;
                        end else if (wrctl_s) begin
                            state <= ST_WAITSTOP;
                        end else begin
                            state <= ST_ACK;
                            // bytes beyond one page are acknowledged but dropped
                            if (page_cnt < PAGE_BYTES) begin
                                page_cnt  <= page_cnt + 5'h01;
                                wrote_any <= 1'b1;
                                req_op    <= OP_WRITE;
                                req_prot  <= prot_sel;
                                req_addr  <= addr;
                                req_data  <= shreg;
                                req_tgl   <= ~req_tgl;
                                addr      <= {addr[7:4], addr[3:0] + 4'h1};
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bitcnt <= 4'h0;
                        state  <= rd_mode ? ST_TXWAIT : ST_RX;
                    end
                end
                ST_TXWAIT: begin
                    // data only goes out once the fetch is back and scl is low
                    if (!hs_pending && !scl_s) begin
                        txsh   <= rd_data;
                        bitcnt <= 4'h0;
                        state  <= ST_TX;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt == 4'h7) begin
                            txsh  <= 8'hff;
                            state <= ST_TACK;
                        end else begin
                            txsh   <= {txsh[6:0], 1'b1};
                            bitcnt <= bitcnt + 4'h1;
                        end
                    end
                end
                ST_TACK: begin
                    if (scl_rise) begin
                        if (!sda_s) begin
                            state    <= ST_TXWAIT;
                            req_op   <= OP_READ;
                            req_prot <= prot_sel;
                            req_addr <= addr;
                            req_tgl  <= ~req_tgl;
                            addr     <= addr + 8'h01;
                        end else begin
                            state <= ST_WAITSTOP;
                        end
                    end
                end
                ST_WAITSTOP: begin
                    state <= ST_WAITSTOP;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // system side: request crossing and service

    always_ff @(posedge mclk) begin
        req_s1 <= req_tgl;
        req_s2 <= req_s1;
        req_s3 <= req_s2;
    end

    assign fifo_in_valid = mpend && (req_op == OP_WRITE) && (m_state == M_IDLE);
    assign service = mpend && (m_state == M_IDLE)
                     && (req_op != OP_WRITE || fifo_in_ready);

    always_ff @(posedge mclk) begin
        if (rst) begin
            mpend   <= 1'b0;
            ack_tgl <= 1'b0;
            rd_data <= RD_RESET;
        end else begin
            // a new request edge wins over a same-cycle service so none is lost
            if (req_s2 ^ req_s3) begin
                mpend <= 1'b1;
            end else if (service) begin
                mpend <= 1'b0;
            end
            if (service) begin
                ack_tgl <= ~ack_tgl;
                if (req_op == OP_READ) begin
                    rd_data <= req_prot ? prot_reg : mem[req_addr];
                end
            end
        end
    end

    stream_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_page_fifo (
        .clk       (mclk),
        .rst       (rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({req_prot, req_addr, req_data}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign fifo_out_ready = (m_state == M_DRAIN);

    ////////////////////////////////////////////////////////////////////////////////
    // program cycle: drain the page, then hold busy for the program time

    always_ff @(posedge mclk) begin
        if (rst) begin
            m_state   <= M_IDLE;
            prog_busy <= 1'b0;
            prog_cnt  <= '0;
        end else begin
            case (m_state)
                M_IDLE: begin
                    if (service && req_op == OP_COMMIT) begin
                        m_state   <= M_DRAIN;
                        prog_busy <= 1'b1;
                    end
                end
                M_DRAIN: begin
                    if (!fifo_out_valid) begin
                        m_state  <= M_PROG;
                        prog_cnt <= '0;
                    end
                end
                M_PROG: begin
                    if (prog_cnt == PROG_LAST) begin
                        m_state   <= M_IDLE;
                        prog_busy <= 1'b0;
                    end else begin
                        prog_cnt <= prog_cnt + 1'b1;
                    end
                end
                default: begin
                    m_state <= M_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            prot_reg <= PROT_RESET;
        end else if (fifo_out_valid && fifo_out_ready && fifo_out_data[FIFO_W-1]) begin
            prot_reg <= fifo_out_data[DATA_W-1:0];
        end
    end

    // array has no reset: contents persist like the real store
    always_ff @(posedge mclk) begin
        if (fifo_out_valid && fifo_out_ready && !fifo_out_data[FIFO_W-1]) begin
            mem[fifo_out_data[DATA_W +: ADDR_W]] <= fifo_out_data[DATA_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_nack;
        state == ST_TACK && scl_rise && sda_s && !start_det && !stop_det;
    endsequence

    sequence s_byte_end;
        state == ST_RX && scl_fall && bitcnt == 4'h8 && !start_det && !stop_det;
    endsequence

    property p_start;
        @(posedge link_clk) disable iff (link_rst)
        start_det |=> (state == ST_RX && bitcnt == 4'h0 && phase == 2'h0);
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_stop;
        @(posedge link_clk) disable iff (link_rst)
        stop_det |=> state == ST_IDLE ##1 (state == ST_IDLE || start_det);
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not give standby");

    property p_nack;
        @(posedge link_clk) disable iff (link_rst)
        s_nack |=> state == ST_WAITSTOP && sda_oe_n;
    endproperty
    a_nack: assert property (p_nack) else $error("kept sending after nack");

    property p_busy_ignore;
        @(posedge link_clk) disable iff (link_rst)
        (s_byte_end and (phase == 2'h0 && busy_s)) |=> state == ST_IDLE && sda_oe_n;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("select taken while busy");

    property p_wrctl_block;
        @(posedge link_clk) disable iff (link_rst)
        (s_byte_end and (phase == 2'h2 && wrctl_s)) |=> state == ST_WAITSTOP && $stable(req_tgl);
    endproperty
    a_wrctl_block: assert property (p_wrctl_block) else $error("write taken with control high");

    property p_page_wrap;
        @(posedge link_clk) disable iff (link_rst)
        (s_byte_end and (phase == 2'h2 && !wrctl_s && page_cnt < PAGE_BYTES))
        |=> addr[7:4] == $past(addr[7:4]) && addr[3:0] == $past(addr[3:0]) + 4'h1;
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page counter wrong");

    property p_match_ack;
        @(posedge link_clk) disable iff (link_rst)
        (s_byte_end and (phase == 2'h0 && sel_match)) |=> !sda_oe_n [*2];
    endproperty
    a_match_ack: assert property (p_match_ack) else $error("select not acknowledged");

    property p_tx_stable;
        @(posedge link_clk) disable iff (link_rst)
        (state == ST_TX && $past(state) == ST_TX && scl_s && scl_d) |-> $stable(sda_oe_n);
    endproperty
    a_tx_stable: assert property (p_tx_stable) else $error("sda moved while scl high");

    property p_commit_busy;
        @(posedge mclk) disable iff (rst)
        (service && req_op == OP_COMMIT) |=> prog_busy [*4];
    endproperty
    a_commit_busy: assert property (p_commit_busy) else $error("program cycle too short");

endmodule // module_info_store

`default_nettype wire

// ### tb/i2c_host_model.sv
// host-side master of the two-wire bus, posting each ack and read byte
// assumes the bench resolves the open-drain data wire and returns it on sda
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model #(
    parameter int Q = 30
) (
    input  wire logic       clk,
    input  wire logic       sda,
    output logic            scl,
    output logic            sda_drv,
    output logic            res_valid,
    output logic            res_is_ack,
    output logic [7:0]      res_data
);
    logic r;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        res_valid = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one phase; callers change only one line per phase to avoid false frames
    task automatic ph(input logic c, input logic d);
        scl = c;
        sda_drv = d;
        repeat (Q) @(posedge clk);
        #1;
    endtask
    task automatic bit_xfer(input logic b);
        ph(1'b0, b);
        ph(1'b1, b);
        r = sda;
        ph(1'b1, b);
        ph(1'b0, b);
    endtask
    task automatic start();
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
        ph(1'b0, 1'b0);
    endtask
    // scl then stays high: the clock stands still between frames
    task automatic stop();
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask
    task automatic post(input logic a, input logic [7:0] v);
        res_is_ack = a;
        res_data = v;
        res_valid = 1'b1;
        @(posedge clk);
        #1;
        res_valid = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--)
            bit_xfer(v[i]);
        bit_xfer(1'b1);
        post(1'b1, {7'h00, ~r});
    endtask
    task automatic get_byte(input logic more);
        logic [7:0] v;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1);
            v[i] = r;
        end
        bit_xfer(~more);
        post(1'b0, v);
    endtask
endmodule  // i2c_host_model
`default_nettype wire

// ### tb/test_module_info_store.sv
// self-checking bench of the module information store slave
// assumes the host model on the bus; notes queue up, results are checked
`timescale 1ns/100ps
`default_nettype none
module test_module_info_store;
    import module_info_pkg::*;
    localparam int PROG_CYC = 4000;
    logic        mclk = 1'b0, link_clk = 1'b0, rst = 1'b1, wr_lock = 1'b0;
    logic [2:0]  s = 3'h0;
    logic        scl, sda_drv, sda_out, sda_oe_n, prog_busy, res_valid, res_is_ack;
    logic [7:0]  res_data;
    logic [31:0] lfsr = 32'hf331cc4f;
    logic [7:0]  d [4];
    logic [9:0]  notes [$];
    logic [9:0]  n;
    int          errors = 0, compares = 0;
    wire logic   sda_wire;
    // open drain: either side pulls low, otherwise the pull-up wins
    assign sda_wire = sda_drv & ((sda_oe_n === 1'b0) ? sda_out : 1'b1);
    always #5 mclk = ~mclk;
    initial begin
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    module_info_store #(.PROG_CYCLES_P(PROG_CYC)) u_module_info_store (
        .mclk(mclk), .rst(rst), .link_clk(link_clk), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .select_strap_bit2(s[2]), .select_strap_bit1(s[1]), .select_strap_bit0(s[0]),
        .write_control_input(wr_lock), .prog_busy(prog_busy)
    );
    i2c_host_model u_i2c_host_model (
        .clk(mclk), .sda(sda_wire), .scl(scl), .sda_drv(sda_drv),
        .res_valid(res_valid), .res_is_ack(res_is_ack), .res_data(res_data)
    );
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic fail(input string m);
        errors++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask
    task automatic check_bit(input logic g, input logic e);
        compares++;
        if (g !== e)
            fail($sformatf("bit %b, expected %b", g, e));
    endtask
    task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e)
            fail($sformatf("byte %h, expected %h", g, e));
    endtask
    task automatic report_and_stop();
        if (notes.size() != 0)
            fail("results missing");
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // note layout: is_ack, care, byte (ack expectation in bit 0)
    task automatic wr(input logic [7:0] v, input logic ack, input logic care = 1'b1);
        notes.push_back({1'b1, care, 7'h00, ack});
        u_i2c_host_model.put_byte(v);
    endtask
    task automatic rd(input logic [7:0] v, input logic more);
        notes.push_back({1'b0, 1'b1, v});
        u_i2c_host_model.get_byte(more);
    endtask
    task automatic sel(input logic [3:0] t, input logic [2:0] st, input logic rw,
                       input logic ack);
        u_i2c_host_model.start();
        wr({t, st, rw}, ack);
    endtask
    task automatic stop();
        u_i2c_host_model.stop();
        repeat (50) @(posedge mclk);
        #1;
    endtask
    task automatic wait_prog();
        for (int i = 0; i < PROG_CYC + 500 && prog_busy !== 1'b0; i++)
            @(posedge mclk);
        repeat (20) @(posedge mclk);
        #1;
        check_bit(prog_busy, 1'b0);
    endtask
    task automatic rnd_read(input logic [3:0] t, input logic [7:0] a);
        sel(t, s, 1'b0, 1'b1);
        wr(a, 1'b1);
        sel(t, s, 1'b1, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        if (res_valid === 1'b1) begin
            if (notes.size() == 0) begin
                fail("result without a note");
            end else begin
                n = notes.pop_front();
                check_bit(res_is_ack, n[9]);
                if (n[9] && n[8])
                    check_bit(res_data[0], n[0]);
                else if (n[8])
                    check_byte(res_data, n[7:0]);
            end
        end
    end
    initial begin
        repeat (95000) @(posedge mclk);
        fail("watchdog expired");
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge mclk);
        #1;
        rst = 1'b0;
        lfsr = lfsr_next(lfsr);
        s = lfsr[2:0];
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            d[i] = lfsr[7:0];
        end
        // bytes without a start must be ignored
        wr({TYPE_MEMORY, s, 1'b1}, 1'b0);
        stop();
        for (int k = 0; k < 3; k++) begin
            sel(TYPE_MEMORY, s ^ 3'(1 << k), 1'b0, 1'b0);
            stop();
        end
        sel(4'h5, s, 1'b0, 1'b0);
        stop();
        $display("test select done");
        sel(TYPE_PROTECT, s, 1'b1, 1'b1);
        rd(PROT_RESET, 1'b0);
        stop();
        $display("test protect reset done");
        sel(TYPE_MEMORY, s, 1'b0, 1'b1);
        wr(8'h3e, 1'b1);
        for (int i = 0; i < 4; i++)
            wr(d[i], 1'b1);
        u_i2c_host_model.stop();
        for (int i = 0; i < 100 && prog_busy !== 1'b1; i++)
            @(posedge mclk);
        #1;
        check_bit(prog_busy, 1'b1);
        sel(TYPE_MEMORY, s, 1'b1, 1'b0);
        stop();
        wait_prog();
        $display("test page write done");
        wr_lock = 1'b1;
        rnd_read(TYPE_MEMORY, 8'h3e);
        rd(d[0], 1'b1);
        rd(d[1], 1'b0);
        rd(8'hff, 1'b0);
        stop();
        rnd_read(TYPE_MEMORY, 8'h30);
        rd(d[2], 1'b0);
        stop();
        sel(TYPE_MEMORY, s, 1'b1, 1'b1);
        rd(d[3], 1'b0);
        stop();
        $display("test reads done");
        sel(TYPE_MEMORY, s, 1'b0, 1'b1);
        wr(8'h3e, 1'b1, 1'b0);
        wr(~d[0], 1'b0);
        stop();
        wait_prog();
        wr_lock = 1'b0;
        rnd_read(TYPE_MEMORY, 8'h3e);
        rd(d[0], 1'b0);
        stop();
        $display("test write blocked done");
        sel(TYPE_PROTECT, s, 1'b0, 1'b1);
        wr(8'h00, 1'b1);
        wr(d[1] ^ 8'h5a, 1'b1);
        stop();
        wait_prog();
        rnd_read(TYPE_PROTECT, 8'h00);
        rd(d[1] ^ 8'h5a, 1'b0);
        stop();
        $display("test protect write done");
        report_and_stop();
    end
endmodule  // test_module_info_store
`default_nettype wire
